// File: inc/pmu_pin_pkg.sv
package pmu_pin_pkg;

  // ----------------------------------------------------------------
  // Bridge select encodings {select_b, select_a}
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    bridge_open         = 2'h0,
    bridge_charge_plus  = 2'h1,
    bridge_charge_minus = 2'h2,
    bridge_grounded     = 2'h3
  } bridge_mode_e;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ           = 25000000;
  localparam int unsigned OFF_HOLD_MS        = 3000;
  localparam int unsigned OFF_HOLD_CYCLES    = (CLOCK_HZ / 1000) * OFF_HOLD_MS;
  localparam int unsigned SYNC_STAGES        = 3;
  localparam logic        CHARGER_RESET      = 1'b0;
  localparam logic        BOOST_RESET        = 1'b0;
  localparam logic [1:0]  BRIDGE_RESET       = 2'h0;
  localparam logic        SYSTEM_ON_RESET    = 1'b1;

  // Bridge mode from the two select lines of a side
  function automatic bridge_mode_e decode_bridge(input logic sel_a, input logic sel_b);
    return bridge_mode_e'({sel_b, sel_a});
  endfunction

endpackage

// File: inc/pmu_pin_if.sv
`timescale 1ns/10ps
interface pmu_pin_if;
  logic power_hold;
  logic charger_enable;
  logic boost_enable;
  logic left_bridge_select_a;
  logic left_bridge_select_b;
  logic right_bridge_select_a;
  logic right_bridge_select_b;
  logic pins_driven;

  modport controller (
    output power_hold, charger_enable, boost_enable, pins_driven,
    output left_bridge_select_a, left_bridge_select_b, right_bridge_select_a, right_bridge_select_b
  );
  modport power_core (
    input power_hold, charger_enable, boost_enable, pins_driven,
    input left_bridge_select_a, left_bridge_select_b, right_bridge_select_a, right_bridge_select_b
  );
endinterface

// File: rtl/pmu_power_core.sv
`timescale 1ns/10ps
// Functional notes
// RULE_01: Hold line governs power-off when bypassing button
// RULE_02: Controller holds line high while on
// RULE_03: Button press starts off-hold timer
// RULE_04: Timer expiry drives hold line low
// RULE_05: Power off on falling edge only
// RULE_06: Both selects low opens side
// RULE_07: Both selects high grounds side
// RULE_08: b low, a high gives charge-plus
// RULE_09: b high, a low gives charge-minus
// RULE_10: Charger and boost enables active high
// RULE_11: Controller drives all lines before use
module pmu_power_core
  import pmu_pin_pkg::*;
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Link from controller
  pmu_pin_if.power_core     link,
  // Power path outputs
  output logic              system_on,
  output logic              charger_on,
  output logic              boost_on,
  output bridge_mode_e      left_mode,
  output bridge_mode_e      right_mode
);

  typedef struct packed {
    logic                   hold_prev;
    logic                   seen_high;
    logic                   system_on;
    logic                   charger_on;
    logic                   boost_on;
    bridge_mode_e           left_mode;
    bridge_mode_e           right_mode;
  } core_s;

  core_s state;
  core_s next_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    // Hold line comes from logic on this clock, so one flop of history suffices
    next_state.hold_prev = link.power_hold;
    if (state.hold_prev && link.power_hold) begin
      next_state.seen_high = 1'b1; // RULE_01
    end
    // Edge, not level: a line held low from reset never powers off
    if (state.seen_high && state.hold_prev && !link.power_hold) begin
      next_state.system_on = 1'b0; // RULE_05
      next_state.seen_high = 1'b0;
    end
    if (link.pins_driven) begin
      next_state.charger_on = link.charger_enable; // RULE_10
      next_state.boost_on   = link.boost_enable; // RULE_10
      next_state.left_mode  = decode_bridge(link.left_bridge_select_a, link.left_bridge_select_b); // RULE_06 RULE_07 RULE_08 RULE_09
      next_state.right_mode = decode_bridge(link.right_bridge_select_a, link.right_bridge_select_b); // RULE_06 RULE_07 RULE_08 RULE_09
    end
    if (!state.system_on) begin
      next_state.charger_on = CHARGER_RESET;
      next_state.boost_on   = BOOST_RESET;
      next_state.left_mode  = bridge_open;
      next_state.right_mode = bridge_open;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state            <= '0;
      state.system_on  <= SYSTEM_ON_RESET;
      state.left_mode  <= bridge_mode_e'(BRIDGE_RESET);
      state.right_mode <= bridge_mode_e'(BRIDGE_RESET);
    end else begin
      state <= next_state;
    end
  end

  assign system_on  = state.system_on;
  assign charger_on = state.charger_on;
  assign boost_on   = state.boost_on;
  assign left_mode  = state.left_mode;
  assign right_mode = state.right_mode;

endmodule // pmu_power_core

// File: rtl/pmu_controller.sv
`timescale 1ns/10ps
module pmu_controller
  import pmu_pin_pkg::*;
#(
  parameter int unsigned OFF_HOLD_COUNT = OFF_HOLD_CYCLES
)(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // User controls
  input  wire logic         button_pressed,
  input  wire logic         charger_request,
  input  wire logic         boost_request,
  input  bridge_mode_e      left_request,
  input  bridge_mode_e      right_request,
  // Status
  output logic              shutting_down,
  // Link to power core
  pmu_pin_if.controller     link
);

  typedef enum logic [1:0] {st_init, st_on, st_counting, st_off} ctl_e;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] btn_sync;
    ctl_e                   phase;
    logic [31:0]            timer;
    logic                   hold;
    logic                   driven;
    logic                   charger;
    logic                   boost;
    logic [1:0]             left;
    logic [1:0]             right;
  } ctl_s;

  ctl_s state;
  ctl_s next_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state          = state;
    next_state.btn_sync = {state.btn_sync[SYNC_STAGES-2:0], button_pressed};
    next_state.charger  = charger_request;
    next_state.boost    = boost_request;
    next_state.left     = left_request;
    next_state.right    = right_request;
    case (state.phase)
      st_init: begin
        next_state.hold   = 1'b1; // RULE_02
        next_state.driven = 1'b1; // RULE_11
        next_state.phase  = st_on;
      end
      st_on: begin
        if (state.btn_sync[1] && state.btn_sync[2]) begin
          next_state.timer = '0; // RULE_03
          next_state.phase = st_counting;
        end
      end
      st_counting: begin
        if (state.timer >= OFF_HOLD_COUNT - 1) begin
          next_state.hold  = 1'b0; // RULE_04
          next_state.phase = st_off;
        end else begin
          next_state.timer = state.timer + 32'h1;
        end
      end
      st_off: begin
        next_state.hold = 1'b0;
      end
      default: next_state.phase = st_init;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state       <= '0;
      state.phase <= st_init;
    end else begin
      state <= next_state;
    end
  end

  assign link.pins_driven           = state.driven; // RULE_11
  assign link.power_hold            = state.hold; // RULE_01
  assign link.charger_enable        = state.charger;
  assign link.boost_enable          = state.boost;
  assign link.left_bridge_select_a  = state.left[0]; // RULE_08 RULE_09
  assign link.left_bridge_select_b  = state.left[1];
  assign link.right_bridge_select_a = state.right[0];
  assign link.right_bridge_select_b = state.right[1];
  assign shutting_down              = (state.phase == st_counting);

endmodule // pmu_controller

// File: verif/pmu_pin_asserts.sv
`timescale 1ns/10ps
module pmu_pin_asserts
  import pmu_pin_pkg::*;
(
  // Clock and reset
  input logic         clock,
  input logic         rstn,
  // Link signals
  input logic         power_hold,
  input logic         charger_enable,
  input logic         boost_enable,
  input logic         left_bridge_select_a,
  input logic         left_bridge_select_b,
  input logic         right_bridge_select_a,
  input logic         right_bridge_select_b,
  input logic         pins_driven,
  // Power core outputs
  input logic         system_on,
  input logic         charger_on,
  input logic         boost_on,
  input bridge_mode_e left_mode,
  input bridge_mode_e right_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Power-off path
  // ----------------------------------------------------------------
  AST_PINS_DRIVEN: assert property ($past(rstn) |-> pins_driven) else $error("link pins not driven");
  AST_HOLD_RISE: assert property ($rose(rstn) |-> ##[1:3] power_hold) else $error("hold not raised");
  AST_LEVEL_ONLY: assert property ($rose(rstn) |-> system_on [*3]) else $error("off on low level");
  AST_OFF_EDGE: assert property ($fell(power_hold) |-> ##[1:4] !system_on) else $error("no power off");
  AST_OFF_HOLD_LOW: assert property (!system_on |-> !power_hold) else $error("hold high while off");
  AST_OFF_FORCED: assert property (!system_on [*2] |-> !charger_on && !boost_on) else $error("enable while off");
  // ----------------------------------------------------------------
  // Bridge and enable decode, one cycle behind the link
  // ----------------------------------------------------------------
  AST_LEFT_MODE: assert property (system_on && $past(system_on) |->
    left_mode == $past({left_bridge_select_b, left_bridge_select_a})) else $error("left mode wrong");
  AST_RIGHT_MODE: assert property (system_on && $past(system_on) |->
    right_mode == $past({right_bridge_select_b, right_bridge_select_a})) else $error("right mode wrong");
  AST_ENABLES: assert property (system_on && $past(system_on) |-> charger_on == $past(charger_enable)
    && boost_on == $past(boost_enable)) else $error("enable decode wrong");
  COV_HOLD_FALL: cover property ($fell(power_hold));
  COV_SPLIT: cover property (left_mode == bridge_charge_plus && right_mode == bridge_charge_minus);
  COV_OFF: cover property ($fell(system_on));
endmodule // pmu_pin_asserts

// File: verif/shutter_pmu_pin_control_tb.sv
`timescale 1ns/10ps
module shutter_pmu_pin_control_tb
  import pmu_pin_pkg::*;
;
  // Short hold count keeps the run brief
  localparam int unsigned HOLD = 10;
  logic         clock = 1'b0;
  logic         rstn = 1'b0;
  logic         button = 1'b0, chg = 1'b0, bst = 1'b0;
  bridge_mode_e lreq = bridge_open, rreq = bridge_open, lmode, rmode;
  logic         sys_on, chg_on, bst_on, stopping;
  int           error_cnt = 0, n_compared = 0, cycles = 0, t0;
  pmu_pin_if link ();
  always #20 clock = ~clock;
  pmu_controller #(.OFF_HOLD_COUNT(HOLD)) i_pmu_controller (.clock(clock), .rstn(rstn), .button_pressed(button),
    .charger_request(chg), .boost_request(bst), .left_request(lreq), .right_request(rreq),
    .shutting_down(stopping), .link(link));
  pmu_power_core i_pmu_power_core (.clock(clock), .rstn(rstn), .link(link), .system_on(sys_on),
    .charger_on(chg_on), .boost_on(bst_on), .left_mode(lmode), .right_mode(rmode));
  pmu_pin_asserts i_pmu_pin_asserts (.clock(clock), .rstn(rstn), .power_hold(link.power_hold),
    .charger_enable(link.charger_enable), .boost_enable(link.boost_enable), .pins_driven(link.pins_driven),
    .left_bridge_select_a(link.left_bridge_select_a), .left_bridge_select_b(link.left_bridge_select_b),
    .right_bridge_select_a(link.right_bridge_select_a), .right_bridge_select_b(link.right_bridge_select_b),
    .system_on(sys_on), .charger_on(chg_on), .boost_on(bst_on), .left_mode(lmode), .right_mode(rmode));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic compare(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic drive(input bridge_mode_e l, input bridge_mode_e r, input logic c, input logic b);
    @(posedge clock);
    lreq <= l;
    rreq <= r;
    chg <= c;
    bst <= b;
  endtask
  // Sampled at negedge so the edge's updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    settle(4);
    compare({link.power_hold, link.pins_driven}, 2'h3);
    compare({sys_on, 1'b0}, 2'h2);
    for (int m = 0; m < 4; m++) begin
      drive(bridge_mode_e'(m), bridge_mode_e'(3 - m), m[0], m[1]);
      settle(3);
      compare({link.left_bridge_select_b, link.left_bridge_select_a}, 2'(m));
      compare({link.right_bridge_select_b, link.right_bridge_select_a}, 2'(3 - m));
      compare(lmode, 2'(m));
      compare(rmode, 2'(3 - m));
      compare({bst_on, chg_on}, 2'(m));
    end
    drive(bridge_grounded, bridge_grounded, 1'b1, 1'b1);
    button <= 1'b1;
    t0 = cycles;
    settle(4);
    compare({stopping, link.power_hold}, 2'h3);
    while (link.power_hold === 1'b1 && cycles < t0 + 100) @(negedge clock);
    compare(2'(cycles - t0 inside {[HOLD:HOLD + 8]}), 2'h1);
    compare({stopping, link.power_hold}, 2'h0);
    settle(4);
    compare({sys_on, chg_on | bst_on}, 2'h0);
    @(posedge clock);
    button <= 1'b0;
    settle(5);
    compare({link.power_hold, sys_on}, 2'h0);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    settle(4);
    compare({link.power_hold, sys_on}, 2'h3);
    tally_and_finish();
  end
endmodule // shutter_pmu_pin_control_tb
